// ### core/tuning_rx_defines.svh
`ifndef TUNING_RX_DEFINES_SVH
`define TUNING_RX_DEFINES_SVH

// Bus addresses selected by the strap pin
`define ADDR_STRAP_LOW      7'h70
`define ADDR_STRAP_HIGH     7'h71
// Data byte field positions
`define ZERO_HI_BIT         7
`define ZERO_LO_BIT         6
`define STANDBY_BIT         5
`define STATE_MSB           4
// Reset values of the applied outputs
`define TUNING_STATE_RESET  5'h00
`define STANDBY_RESET       1'b0
// Settling time after a change, in ns, and the derived cycle count
`define SETTLE_TIME_NS      12000
`define CLK_PERIOD_NS       10
`define SETTLE_CYCLES       (`SETTLE_TIME_NS / `CLK_PERIOD_NS)
// Telegram phase lengths in bits
`define BYTE_BITS           8

`endif

// ### core/tuning_rx_pkg.sv
package tuning_rx_pkg;

  // Applied tuning word
  typedef struct packed {
    logic       standby_request_bit;
    logic [4:0] tuning_state_field;
  } tuning_word_t;

  // Receiver phases, one-hot
  typedef enum logic [5:0] {
    ST_IDLE     = 6'h01,
    ST_ADDR     = 6'h02,
    ST_ADDR_ACK = 6'h04,
    ST_DATA     = 6'h08,
    ST_DATA_ACK = 6'h10,
    ST_IGNORE   = 6'h20
  } rx_state_t;

endpackage : tuning_rx_pkg

// ### core/pin_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for one asynchronous pin
module pin_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input  wire logic CLK,
  input  wire logic RST_N,
  input  wire logic d,
  output logic      q
);

  logic meta_r;

  // Only the second flop is read outside
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      meta_r <= RESET_VAL;                // Idle level, so no false edge
      q      <= RESET_VAL;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule : pin_sync

// ### core/tuning_state_receiver.sv
`timescale 1ns/1ps
`include "tuning_rx_defines.svh"

// Contract
// - Each telegram bit is sampled on a rising serial clock edge.
// - A data byte is applied at the rising edge of its ack clock.
// - With the strap high the slave answers only address 113.
// - With the strap low the slave answers only address 112.
// - Other addresses are ignored; the master picks by strapped address.
// - Data is MSB first; bits 7:6 zero, bit 5 standby, bits 4:0 state.
// - The 5-bit tuning state picks one of 32 settings, zero minimum.
// - An applied change settles within 12 us of the activating edge.
module tuning_state_receiver
  import tuning_rx_pkg::*;
#(
  parameter int SETTLE_CYCLES = `SETTLE_CYCLES
) (
  input  wire logic       CLK,
  input  wire logic       RST_N,
  input  wire logic       SCL_IN,
  input  wire logic       SDA_IN,
  input  wire logic       ADDR_STRAP,
  output logic            SDA_OUT,
  output logic            SDA_OE,
  output logic [4:0]      TUNING_STATE,
  output logic            STANDBY,
  output logic            SETTLING,
  output logic            FRAME_ERROR
);

  // Settle counter is 16 bits wide
  if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65535) begin : g_bad_settle
    $error("SETTLE_CYCLES out of range");
  end

  logic scl_s;
  logic sda_s;
  logic strap_s;
  logic scl_d_r;
  logic sda_d_r;
  rx_state_t    state_r;
  rx_state_t    state_nxt;
  logic [7:0]   shift_r;
  logic [3:0]   bit_cnt_r;
  logic [15:0]  settle_cnt_r;
  tuning_word_t word_r;
  logic         ack_seen_r;
  logic         fall_seen_r;

  // Pins cross into the CLK domain before anything reads them
  pin_sync #(.RESET_VAL(1'b1)) u_scl_sync (
    .CLK       (CLK),
    .RST_N     (RST_N),
    .d         (SCL_IN),
    .q         (scl_s)
  );
  pin_sync #(.RESET_VAL(1'b1)) u_sda_sync (
    .CLK       (CLK),
    .RST_N     (RST_N),
    .d         (SDA_IN),
    .q         (sda_s)
  );
  pin_sync #(.RESET_VAL(1'b0)) u_strap_sync (
    .CLK       (CLK),
    .RST_N     (RST_N),
    .d         (ADDR_STRAP),
    .q         (strap_s)
  );

  // Edge and condition detection on the synchronised lines
  wire scl_rise  = scl_s & ~scl_d_r;
  wire scl_fall  = ~scl_s & scl_d_r;
  wire start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;
  wire shift_en  = scl_rise & ((state_r == ST_ADDR) | (state_r == ST_DATA));
  wire byte_done = shift_en & (bit_cnt_r == 4'h7);
  wire in_ack    = (state_r == ST_ADDR_ACK) | (state_r == ST_DATA_ACK);

  // Address match; the last bit of the byte is the direction bit
  wire [6:0] own_addr   = strap_s ? `ADDR_STRAP_HIGH
                                  : `ADDR_STRAP_LOW;
  wire [7:0] rx_byte    = {shift_r[6:0], sda_s};
  wire       addr_match = (rx_byte[7:1] == own_addr)
                          & ~rx_byte[0];
  wire       zeros_ok   = ~shift_r[`ZERO_HI_BIT]
                          & ~shift_r[`ZERO_LO_BIT];
  wire       apply_now  = (state_r == ST_DATA_ACK) & scl_rise;

  // Phase sequencing of the telegram
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:     state_nxt = ST_IDLE;
      ST_ADDR:     if (byte_done) begin
                     state_nxt = addr_match ? ST_ADDR_ACK : ST_IGNORE;
                   end
      ST_ADDR_ACK: if (scl_fall & ack_seen_r) begin
                     state_nxt = ST_DATA;
                   end
      ST_DATA:     if (byte_done) begin
                     state_nxt = ST_DATA_ACK;
                   end
      ST_DATA_ACK: if (scl_fall & ack_seen_r) begin
                     state_nxt = ST_DATA;
                   end
      ST_IGNORE:   state_nxt = ST_IGNORE;
      default:     state_nxt = ST_IDLE;
    endcase
    if (start_det) begin
      state_nxt = ST_ADDR;
    end else if (stop_det) begin
      state_nxt = ST_IDLE;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      state_r <= ST_IDLE;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      state_r <= state_nxt;
    end
  end

  // Bit shifting, sampled on rising clock edges, MSB first
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      shift_r   <= 8'h00;
      bit_cnt_r <= 4'h0;
    end else begin
      // The eighth bit is kept too; the ack slot reads the whole byte
      if (shift_en) begin
        shift_r <= rx_byte;
      end
      if (start_det || byte_done) begin
        bit_cnt_r <= 4'h0;
      end else if (shift_en) begin
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
    end
  end

  // Ack slot tracking: rising edge seen inside the slot
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ack_seen_r <= 1'b0;
    end else if (!in_ack) begin
      ack_seen_r <= 1'b0;
    end else if (scl_rise) begin
      ack_seen_r <= 1'b1;
    end
  end

  // Fall of the eighth bit seen inside the slot
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      fall_seen_r <= 1'b0;
    end else if (!in_ack) begin
      fall_seen_r <= 1'b0;
    end else if (scl_fall) begin
      fall_seen_r <= 1'b1;
    end
  end

  // Drive low only once the clock is low; pulling data during the high
  // half of the eighth bit would look like a start condition
  wire ack_slot  = (state_nxt == ST_ADDR_ACK)
                   | (state_nxt == ST_DATA_ACK);
  wire ack_drive = ack_slot & (fall_seen_r | scl_fall);

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      SDA_OE  <= 1'b0;
      SDA_OUT <= 1'b1;
    end else begin
      SDA_OE  <= ack_drive;
      SDA_OUT <= ~ack_drive;
    end
  end

  // Apply at the ack rising edge; bad high bits flag and are dropped
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      word_r      <= '{`STANDBY_RESET, `TUNING_STATE_RESET};
      FRAME_ERROR <= 1'b0;
    end else if (apply_now && !ack_seen_r) begin
      if (zeros_ok) begin
        word_r.standby_request_bit <= shift_r[`STANDBY_BIT];
        word_r.tuning_state_field  <= shift_r[`STATE_MSB:0];
        FRAME_ERROR <= 1'b0;
      end else begin
        FRAME_ERROR <= 1'b1;
      end
    end
  end

  // Settle window; a change holds SETTLING for the full count
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      settle_cnt_r <= 16'h0000;
      SETTLING     <= 1'b0;
    end else if (apply_now && !ack_seen_r && zeros_ok) begin
      settle_cnt_r <= 16'(SETTLE_CYCLES);
      SETTLING     <= 1'b1;
    end else if (settle_cnt_r != 16'h0000) begin
      settle_cnt_r <= settle_cnt_r - 16'h0001;
      SETTLING     <= (settle_cnt_r != 16'h0001);
    end
  end

  // Outputs registered from the applied word register, one cycle later
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      TUNING_STATE <= `TUNING_STATE_RESET;
      STANDBY      <= `STANDBY_RESET;
    end else begin
      TUNING_STATE <= word_r.tuning_state_field;
      STANDBY      <= word_r.standby_request_bit;
    end
  end

endmodule : tuning_state_receiver

// ### sim/tuning_rx_props.sv
`timescale 1ns/1ps
module tuning_rx_props #(
  parameter int SETTLE_CYCLES = 8
) (
  input wire logic       CLK,
  input wire logic       RST_N,
  input wire logic       SCL_IN,
  input wire logic       SDA_IN,
  input wire logic       ADDR_STRAP,
  input wire logic       SDA_OUT,
  input wire logic       SDA_OE,
  input wire logic [4:0] TUNING_STATE,
  input wire logic       STANDBY,
  input wire logic       SETTLING,
  input wire logic       FRAME_ERROR
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  int run_cnt;
  // Length of the current settling run
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N)
      run_cnt <= 0;
    else
      run_cnt <= SETTLING ? run_cnt + 1 : 0;
  end
  logic in_rst_r = 1'b0;
  // Reset seen at an earlier edge; the first edge may still show unknowns
  always @(posedge CLK) begin
    in_rst_r <= !RST_N;
  end
  sequence applied;
    $changed(TUNING_STATE) || $changed(STANDBY);
  endsequence
  sequence word_held;
    $stable(TUNING_STATE) && $stable(STANDBY);
  endsequence
  oe_low_a: assert property (SDA_OE |-> !SDA_OUT)
    else $error("ack drive not low");
  oe_hold_a: assert property (SDA_OE && SCL_IN |=> SDA_OE)
    else $error("ack dropped while clock high");
  oe_release_a: assert property ($fell(SDA_OE) |-> !SCL_IN)
    else $error("ack released with clock high");
  apply_edge_a: assert property (applied |-> SCL_IN)
    else $error("word applied outside clock high");
  settle_start_a: assert property (applied |-> ##[0:1] SETTLING)
    else $error("no settling after change");
  settle_len_a: assert property ($fell(SETTLING) |->
    run_cnt == SETTLE_CYCLES)
    else $error("settling length wrong");
  bad_byte_a: assert property ($rose(FRAME_ERROR) |-> word_held[*3])
    else $error("bad byte applied");
  reset_word_a: assert property (disable iff (1'b0)
    !RST_N && in_rst_r |-> !STANDBY && TUNING_STATE == 5'h00
    && SDA_OUT && !SDA_OE)
    else $error("reset values wrong");
endmodule : tuning_rx_props

// ### sim/twowire_master.sv
`timescale 1ns/1ps
// Bus master; clock stands high between frames
module twowire_master (
  input  wire logic clk,
  input  wire logic sda_i,
  output logic      scl,
  output logic      sda_o
);
  initial begin
    scl = 1'b1;
    sda_o = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask : wt
  // Data moves only in the low half of the clock
  task automatic bit_io(input logic b, output logic r);
    wt(3);
    sda_o = b;
    wt(5);
    scl = 1'b1;
    wt(4);
    r = sda_i;
    wt(4);
    scl = 1'b0;
  endtask : bit_io
  task automatic start();
    wt(8);
    sda_o = 1'b0;
    wt(8);
    scl = 1'b0;
  endtask : start
  task automatic stop();
    wt(3);
    sda_o = 1'b0;
    wt(5);
    scl = 1'b1;
    wt(8);
    sda_o = 1'b1;
  endtask : stop
  // Released line floats to the pull-up for the ack
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask : put_byte
endmodule : twowire_master

// ### sim/tuning_state_receiver_test.sv
`timescale 1ns/1ps
module tuning_state_receiver_test;
  logic       clk;
  logic       rst_n;
  logic       strap;
  wire        scl;
  wire        sda_m;
  logic       sda_oe;
  logic       sda_out;
  logic       stby;
  logic       ferr;
  logic       settling;
  logic [4:0] state;
  int         n_fail;
  int         total_checks;
  // Open-drain data line with pull-up
  wire sda = sda_m & (sda_oe ? sda_out : 1'b1);
  tuning_state_receiver #(.SETTLE_CYCLES(8)) dut (.CLK(clk), .RST_N(rst_n),
    .SCL_IN(scl), .SDA_IN(sda), .ADDR_STRAP(strap), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe), .TUNING_STATE(state), .STANDBY(stby),
    .SETTLING(settling), .FRAME_ERROR(ferr));
  twowire_master mst (.clk(clk), .sda_i(sda), .scl(scl), .sda_o(sda_m));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic end_sim();
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_sim
  task automatic check(input string nm, input logic [6:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask : check
  // Word is checked before the stop, right after the data ack
  task automatic xfer(input logic [6:0] a, input logic [7:0] d,
                      input logic ak, input logic [6:0] exp);
    logic a1;
    logic a2;
    mst.start();
    mst.put_byte({a, 1'b0}, a1);
    check("addr ack", 7'(a1), 7'(ak));
    mst.put_byte(d, a2);
    check("data ack", 7'(a2), 7'(ak));
    check("word", {ferr, stby, state}, exp);
    check("settling", 7'(settling), 7'(ak & ~d[7] & ~d[6]));
    mst.stop();
  endtask : xfer
  task automatic test_strap_low();
    strap = 1'b0;
    xfer(7'h71, 8'h1F, 1'b0, 7'h00);
    xfer(7'h70, 8'h15, 1'b1, 7'h15);
    $display("strap low done");
  endtask : test_strap_low
  task automatic test_strap_high();
    strap = 1'b1;
    xfer(7'h70, 8'h0A, 1'b0, 7'h15);
    xfer(7'h71, 8'h3F, 1'b1, 7'h3F);
    $display("strap high done");
  endtask : test_strap_high
  task automatic test_fields();
    logic a1;
    // Read direction is refused with no ack
    mst.start();
    mst.put_byte(8'hE3, a1);
    check("read nack", 7'(a1), 7'h00);
    mst.stop();
    xfer(7'h71, 8'h81, 1'b1, 7'h7F);
    xfer(7'h71, 8'h40, 1'b1, 7'h7F);
    xfer(7'h71, 8'h20, 1'b1, 7'h20);
    xfer(7'h71, 8'h00, 1'b1, 7'h00);
    $display("fields done");
  endtask : test_fields
  initial begin
    rst_n = 1'b0;
    strap = 1'b0;
    n_fail = 0;
    total_checks = 0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (8) @(negedge clk);
    test_strap_low();
    test_strap_high();
    test_fields();
    end_sim();
  end
  // Nine frames need about 3000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_sim();
  end
endmodule : tuning_state_receiver_test
bind tuning_state_receiver tuning_rx_props #(.SETTLE_CYCLES(SETTLE_CYCLES))
  props (.CLK(CLK), .RST_N(RST_N), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN),
  .ADDR_STRAP(ADDR_STRAP), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
  .TUNING_STATE(TUNING_STATE), .STANDBY(STANDBY), .SETTLING(SETTLING),
  .FRAME_ERROR(FRAME_ERROR));
